// File: design/tkoc_pkg.sv
// Shared constants and types for the touch key output control block
package tkoc_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ         = 100_000_000;
    localparam int unsigned SETTLE_TIME_MS = 500;
    localparam int unsigned WATCH_TIME_MS  = 16000;
    localparam logic [31:0] SETTLE_CYCLES  = 32'(SETTLE_TIME_MS * (CLK_HZ / 1000));
    localparam logic [31:0] WATCH_CYCLES   = 32'(WATCH_TIME_MS * (CLK_HZ / 1000));
    localparam logic [7:0]  DRIFT_PERIOD   = 8'h40;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_CTRL     = 12'h000;
    localparam logic [11:0] ADDR_STATUS   = 12'h004;
    localparam logic [11:0] ADDR_CONFIG   = 12'h008;
    localparam logic [11:0] ADDR_BASELINE = 12'h00c;

    localparam int CTRL_RECAL_BIT = 0;
    localparam int CTRL_DRIFT_BIT = 1;
    localparam logic CTRL_DRIFT_RESET = 1'b1;

    localparam int STAT_TOUCH_BIT  = 0;
    localparam int STAT_KEY_BIT    = 1;
    localparam int STAT_SETTLE_BIT = 2;
    localparam int STAT_TOG_BIT    = 3;
    localparam int STAT_PIN_BIT    = 4;

    localparam int CFG_FORM_BIT = 0;
    localparam int CFG_THR_LSB  = 8;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    localparam logic FORM_DIRECT = 1'b0;
    localparam logic FORM_TOGGLE = 1'b1;

    typedef enum logic [1:0] {
        ST_SETTLE = 2'b01,
        ST_RUN    = 2'b10
    } tkoc_state_t;
endpackage : tkoc_pkg

// File: design/tkoc_top.sv
// Touch key output control: detection, output forms, timers, APB registers
//
// How it works
// - Direct form: drive key low while touched, else release; released at power-up.
// - Toggle form selected by fuse value one; open drain, released at power-up.
// - Watch timer limits continuous key assertion to sixteen seconds.
// - Timer expiry restores power-up state; key stays off until fresh detection.
// - First half second after power-up: detection and output disabled.
// - Fuse contents latched once after power-up and used thereafter.
// - Unprogrammed fuse bits read as zero, giving direct form defaults.
// - Touch declared when count exceeds baseline by more than fuse threshold.
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/100ps
module tkoc_top #(
    parameter logic [31:0] SETTLE_CYCLES = tkoc_pkg::SETTLE_CYCLES,
    parameter logic [31:0] WATCH_CYCLES  = tkoc_pkg::WATCH_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [15:0] sense_count,
    input  wire logic        sense_valid,
    input  wire logic        fuse_output_form,
    input  wire logic [7:0]  fuse_threshold,
    input  wire logic        key_out_n_in,
    output logic             key_out_n_out,
    output logic             key_out_n_oe
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    tkoc_pkg::tkoc_state_t state;
    logic        fuse_done;
    logic        output_form_select;
    logic [7:0]  threshold;
    logic [15:0] sample;
    logic [15:0] baseline;
    logic [7:0]  drift_cnt;
    logic [31:0] settle_cnt;
    logic [31:0] watch_cnt;
    logic        touch_prev;
    logic        tog_state;
    logic        key_drive;
    logic        drift_en;
    logic        recal_req;
    logic        touch;
    logic        onset;
    logic        settle_done;
    logic        watch_expire;
    logic        recapture;
    logic        next_tog;
    logic        wr_en;
    logic        rd_setup;
    logic [3:0]  sel;

    function automatic logic [3:0] reg_sel(input logic [11:0] a);
        reg_sel = {a == tkoc_pkg::ADDR_BASELINE, a == tkoc_pkg::ADDR_CONFIG,
                   a == tkoc_pkg::ADDR_STATUS, a == tkoc_pkg::ADDR_CTRL};
    endfunction : reg_sel

    // ------------------------------------------------------------
    // Fuse latch
    // ------------------------------------------------------------
    // Fuses are read one cycle after release, never under reset
    always_ff @(posedge clk) begin
        if (rst) begin
            fuse_done          <= 1'b0;
            output_form_select <= tkoc_pkg::FORM_DIRECT;
            threshold          <= 8'h00;
        end else if (!fuse_done) begin
            fuse_done          <= 1'b1;
            output_form_select <= fuse_output_form;
            threshold          <= fuse_threshold;
        end
    end

    // ------------------------------------------------------------
    // Detection
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            sample <= 16'h0000;
        end else if (sense_valid) begin
            sample <= sense_count;
        end
    end

    assign touch = (state == tkoc_pkg::ST_RUN)
                 && ({1'b0, sample} > ({1'b0, baseline} + {9'h000, threshold}));
    assign onset = touch && !touch_prev;
    assign settle_done = (state == tkoc_pkg::ST_SETTLE) && (settle_cnt == SETTLE_CYCLES - 1);
    assign watch_expire = key_drive && (watch_cnt == WATCH_CYCLES - 1);
    assign recapture = settle_done || watch_expire || recal_req;

    always_ff @(posedge clk) begin
        if (rst) begin
            state      <= tkoc_pkg::ST_SETTLE;
            settle_cnt <= 32'h0000_0000;
        end else begin
            case (state)
                tkoc_pkg::ST_SETTLE: begin
                    settle_cnt <= settle_cnt + 32'h0000_0001;
                    if (settle_done) begin
                        state <= tkoc_pkg::ST_RUN;
                    end
                end
                tkoc_pkg::ST_RUN: begin
                    settle_cnt <= 32'h0000_0000;
                end
                default: begin
                    state      <= tkoc_pkg::ST_SETTLE;
                    settle_cnt <= 32'h0000_0000;
                end
            endcase
        end
    end

    // Drift steps by one count, slowly, so a slow finger is not absorbed
    always_ff @(posedge clk) begin
        if (rst) begin
            baseline  <= 16'h0000;
            drift_cnt <= 8'h00;
        end else if (recapture) begin
            baseline  <= sample;
            drift_cnt <= 8'h00;
        end else if (state == tkoc_pkg::ST_RUN && !touch && drift_en && sense_valid) begin
            if (drift_cnt == tkoc_pkg::DRIFT_PERIOD - 8'h01) begin
                drift_cnt <= 8'h00;
                if (sample > baseline) begin
                    baseline <= baseline + 16'h0001;
                end else if (sample < baseline) begin
                    baseline <= baseline - 16'h0001;
                end
            end else begin
                drift_cnt <= drift_cnt + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Output forms and watch timer
    // ------------------------------------------------------------
    assign next_tog = onset ? !tog_state : tog_state;

    // After expiry touch_prev is forced so a held touch is not a new onset
    always_ff @(posedge clk) begin
        if (rst) begin
            touch_prev <= 1'b0;
            tog_state  <= 1'b0;
        end else if (watch_expire) begin
            touch_prev <= 1'b1;
            tog_state  <= 1'b0;
        end else begin
            touch_prev <= touch;
            if (output_form_select == tkoc_pkg::FORM_TOGGLE) begin
                tog_state <= next_tog;
            end else begin
                tog_state <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            key_drive <= 1'b0;
        end else if (state != tkoc_pkg::ST_RUN || watch_expire) begin
            key_drive <= 1'b0;
        end else if (output_form_select == tkoc_pkg::FORM_TOGGLE) begin
            key_drive <= next_tog;
        end else begin
            key_drive <= touch;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || !key_drive || watch_expire) begin
            watch_cnt <= 32'h0000_0000;
        end else begin
            watch_cnt <= watch_cnt + 32'h0000_0001;
        end
    end

    assign key_out_n_out = 1'b0;
    assign key_out_n_oe  = key_drive;

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && (reg_sel(paddr) == 4'h0);
    assign wr_en    = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign sel      = reg_sel(paddr);

    always_ff @(posedge clk) begin
        if (rst) begin
            drift_en  <= tkoc_pkg::CTRL_DRIFT_RESET;
            recal_req <= 1'b0;
        end else begin
            recal_req <= wr_en && sel[0] && pwdata[tkoc_pkg::CTRL_RECAL_BIT];
            if (wr_en && sel[0]) begin
                drift_en <= pwdata[tkoc_pkg::CTRL_DRIFT_BIT];
            end
        end
    end

    // Read data is captured in setup so it stands stable through access
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= 32'h0000_0000;
            case (reg_sel(paddr))
                4'h1: prdata[tkoc_pkg::CTRL_DRIFT_BIT] <= drift_en;
                4'h2: begin
                    prdata[tkoc_pkg::STAT_TOUCH_BIT]  <= touch;
                    prdata[tkoc_pkg::STAT_KEY_BIT]    <= key_drive;
                    prdata[tkoc_pkg::STAT_SETTLE_BIT] <= state == tkoc_pkg::ST_SETTLE;
                    prdata[tkoc_pkg::STAT_TOG_BIT]    <= tog_state;
                    prdata[tkoc_pkg::STAT_PIN_BIT]    <= key_out_n_in;
                end
                4'h4: begin
                    prdata[tkoc_pkg::CFG_FORM_BIT] <= output_form_select;
                    prdata[tkoc_pkg::CFG_THR_LSB +: 8] <= threshold;
                end
                4'h8: prdata[15:0] <= baseline;
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence onset_s;
        output_form_select && onset && !watch_expire && state == tkoc_pkg::ST_RUN;
    endsequence

    sequence hold_s;
        output_form_select && !onset && !watch_expire;
    endsequence

    settle_quiet_a: assert property ((state == tkoc_pkg::ST_SETTLE) |=> !touch_prev ##0 (!key_out_n_oe || state == tkoc_pkg::ST_RUN)) else $error("key driven while settling");
    direct_follow_a: assert property ((!output_form_select && touch && !watch_expire) |=> key_out_n_oe) else $error("direct form missed touch");
    direct_release_a: assert property ((fuse_done && !output_form_select && !touch) |=> !key_out_n_oe) else $error("direct form held without touch");
    toggle_flip_a: assert property (onset_s |=> key_out_n_oe == !$past(tog_state)) else $error("toggle did not invert");
    toggle_hold_a: assert property (hold_s |=> $stable(tog_state)) else $error("toggle changed without onset");
    watch_limit_a: assert property (key_out_n_oe |-> watch_cnt < WATCH_CYCLES) else $error("key held past limit");
    expire_clear_a: assert property (watch_expire |=> !key_out_n_oe && !tog_state ##1 !onset) else $error("expiry left key active");
    fuse_hold_a: assert property (fuse_done |=> $stable(output_form_select) && $stable(threshold)) else $error("fuse copy changed");
    baseline_take_a: assert property (settle_done |=> baseline == $past(sample) && state == tkoc_pkg::ST_RUN) else $error("baseline not captured");
endmodule : tkoc_top

// File: testbench/testbench.sv
// Self-checking bench for the touch key output control block
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module testbench;
    localparam logic [31:0] SETTLE = 32'h14;
    localparam logic [31:0] WATCH  = 32'h32;

    logic        clk              = 1'b0;
    logic        rst              = 1'b1;
    logic        psel             = 1'b0;
    logic        penable          = 1'b0;
    logic        pwrite           = 1'b0;
    logic [11:0] paddr            = 12'h000;
    logic [31:0] pwdata           = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [15:0] sense_count      = 16'h0;
    logic        sense_valid      = 1'b0;
    logic        fuse_output_form = 1'b0;
    logic [7:0]  fuse_threshold   = 8'h0a;
    logic        key_line;
    logic        key_out_n_out;
    logic        key_out_n_oe;
    logic [31:0] rd;
    logic        err;
    int          n_fail           = 0;
    int          num_checks       = 0;
    int          cnt;

    always #5 clk = ~clk;

    tkoc_top #(.SETTLE_CYCLES(SETTLE), .WATCH_CYCLES(WATCH)) DUT (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sense_count(sense_count), .sense_valid(sense_valid),
        .fuse_output_form(fuse_output_form), .fuse_threshold(fuse_threshold),
        .key_out_n_in(key_line), .key_out_n_out(key_out_n_out),
        .key_out_n_oe(key_out_n_oe));

    tkoc_host_model host (
        .key_out_n_out(key_out_n_out), .key_out_n_oe(key_out_n_oe), .key_line(key_line));

    // ------------------------------------------------------------
    // Bus and stimulus tasks
    // ------------------------------------------------------------
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int w;
        w = 0;
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            w++;
        end while (pready !== 1'b1 && w < 100);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask : rd_chk

    // One qualified sample, then time for touch and key to follow
    task automatic sense(input logic [15:0] v);
        sense_count <= v;
        sense_valid <= 1'b1;
        @(posedge clk);
        sense_valid <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : sense

    task automatic reset_dut(input logic form);
        rst <= 1'b1;
        fuse_output_form <= form;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
    endtask : reset_dut

    task automatic conclude();
        $display("checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        @(posedge clk);
        reset_dut(1'b0);
        sense(16'h012c);
        `CHK(key_out_n_oe, 1'b0)
        rd_chk(tkoc_pkg::ADDR_STATUS, 32'h14);
        sense(16'h0064);
        repeat (12) @(posedge clk);
        rd_chk(tkoc_pkg::ADDR_BASELINE, 32'h64);
        rd_chk(tkoc_pkg::ADDR_CONFIG, 32'h0a00);
        `CHK(rd[0], tkoc_pkg::FORM_DIRECT)
        apb(1'b1, tkoc_pkg::ADDR_CTRL, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        $display("settle and registers done");
        sense(16'h006e);
        `CHK(key_out_n_oe, 1'b0)
        sense(16'h006f);
        `CHK({key_out_n_oe, key_line}, 2'b10)
        rd_chk(tkoc_pkg::ADDR_STATUS, 32'h03);
        sense(16'h0064);
        `CHK({key_out_n_oe, key_line}, 2'b01)
        $display("direct form done");
        sense(16'h00c8);
        cnt = 1;
        while (key_out_n_oe === 1'b1 && cnt < 300) begin
            @(posedge clk);
            cnt++;
        end
        `CHK((cnt >= WATCH - 3) && (cnt <= WATCH + 1), 1'b1)
        repeat (10) @(posedge clk);
        `CHK(key_out_n_oe, 1'b0)
        rd_chk(tkoc_pkg::ADDR_BASELINE, 32'hc8);
        $display("watch timer done");
        apb(1'b1, 12'h010, 32'h3);
        `CHK(err, 1'b1)
        sense(16'h0080);
        apb(1'b1, tkoc_pkg::ADDR_CTRL, 32'h1);
        rd_chk(tkoc_pkg::ADDR_BASELINE, 32'h80);
        rd_chk(tkoc_pkg::ADDR_CTRL, 32'h0);
        apb(1'b1, tkoc_pkg::ADDR_CTRL, 32'h2);
        repeat (64) sense(16'h0085);
        rd_chk(tkoc_pkg::ADDR_BASELINE, 32'h81);
        rd_chk(tkoc_pkg::ADDR_CTRL, 32'h2);
        `CHK(key_out_n_oe, 1'b0)
        $display("recapture and drift done");
        reset_dut(1'b1);
        sense(16'h0064);
        repeat (20) @(posedge clk);
        apb(1'b1, tkoc_pkg::ADDR_CTRL, 32'h0);
        fuse_output_form <= 1'b0;
        rd_chk(tkoc_pkg::ADDR_CONFIG, 32'h0a01);
        sense(16'h00c8);
        `CHK(key_out_n_oe, 1'b1)
        sense(16'h0064);
        `CHK(key_out_n_oe, 1'b1)
        rd_chk(tkoc_pkg::ADDR_STATUS, 32'h0a);
        sense(16'h00c8);
        `CHK({key_out_n_oe, key_line}, 2'b01)
        sense(16'h0064);
        $display("toggle form done");
        conclude();
    end

    // Whole run is a few hundred cycles; this leaves ample margin
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        $display("unexpected at %0t: watchdog expired", $time);
        conclude();
    end
endmodule : testbench

// File: testbench/tkoc_host_model.sv
// Host side of the key line: pull-up resistor on the open-drain pin
`timescale 1ns/100ps
module tkoc_host_model (
    input  wire logic key_out_n_out,
    input  wire logic key_out_n_oe,
    output logic      key_line
);
    // ------------------------------------------------------------
    // Wire resolution
    // ------------------------------------------------------------
    // Released pin floats up to the pull-up, never keeps the last level
    assign key_line = (key_out_n_oe === 1'b1) ? key_out_n_out : 1'b1;
endmodule : tkoc_host_model
